// ---- hw/ssr_pkg.sv ----
`default_nettype none
package ssr_pkg;
    // protection bit layout
    localparam int PROT_CV_BIT    = 0;
    localparam int PROT_CC_BIT    = 1;
    localparam int PROT_OV_BIT    = 3;
    localparam int PROT_OT_BIT    = 4;
    localparam int PROT_SHDN_BIT  = 5;
    localparam int PROT_FOLD_BIT  = 6;
    localparam int PROT_PROG_BIT  = 7;
    localparam logic [7:0] PROT_USED_MASK = 8'hfb;
    localparam logic [7:0] PROT_MODE_MASK = 8'h43;
    // standard event layout
    localparam logic [7:0] STD_USED_MASK  = 8'hbd;
    // status byte layout
    localparam int STB_PROT_BIT   = 1;
    localparam int STB_STD_BIT    = 5;
    localparam int STB_RQS_BIT    = 6;
    localparam logic [7:0] STB_SRC_MASK   = 8'hbf;
    // reset values
    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [7:0] STD_RESET      = 8'h80;
    // register selects on the command strobe port
    localparam logic [2:0] SEL_PROT_LIVE  = 3'h0;
    localparam logic [2:0] SEL_PROT_EVT   = 3'h1;
    localparam logic [2:0] SEL_PROT_MASK  = 3'h2;
    localparam logic [2:0] SEL_STD_EVT    = 3'h3;
    localparam logic [2:0] SEL_STD_MASK   = 3'h4;
    localparam logic [2:0] SEL_STB        = 3'h5;
    localparam logic [2:0] SEL_SRQ_MASK   = 3'h6;
    localparam logic [2:0] SEL_POLL       = 3'h7;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] sel;
        logic [7:0] wdata;
    } ssr_acc_t;

    typedef struct packed {
        logic clear_status;
        logic reset_cmd;
    } ssr_cmd_t;
endpackage : ssr_pkg
`default_nettype wire

// ---- hw/ssr_mask_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// three host-owned enable masks
module ssr_mask_regs #(
    parameter int N = 3
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // write side
    input  wire logic [N-1:0] we,
    input  wire logic [7:0]   wdata,
    input  wire logic         clr_all,
    // mask contents
    output logic [N-1:0][7:0] mask
);
    logic [N-1:0][7:0] next_mask;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            next_mask[i] = mask[i];
            if (clr_all)
                next_mask[i] = ssr_pkg::MASK_RESET;
            else if (we[i])
                next_mask[i] = wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn)
            mask <= '0;
        else
            mask <= next_mask;
    end
endmodule : ssr_mask_regs
`default_nettype wire

// ---- hw/ssr_status.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01: live protection state read unlatched
// R02: reading latched protection events clears them
// R03: clear-status or reset command clears protection events
// R04: event latches only when enabled, stays set
// R05: shared protection bit layout, bit2 unused
// R06: protection mask readable, writable, filters only
// R07: disabled mode bits never cause shutdown
// R08: host programs both masks for requests
// R09: standard events cleared by read, clear-status
// R10: standard event layout, bits 1,6 unused
// R11: enabled standard events ORed into bit5
// R12: status byte by query or poll; clear-status clears
// R13: service mask uses status byte positions
// R14: enabled status bit sets request-service bit
// R15: service request line on GPIB only
// R16: poll returns request-service bit, then clears
// R17: summary follows enabled events, cleared by read
// R18: single-cycle strobes, read side effects on strobe
module ssr_status (
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            rstn,
    // command interpreter access
    input  wire ssr_pkg::ssr_acc_t acc,
    input  wire ssr_pkg::ssr_cmd_t cmd,
    input  wire logic            gpib_sel,
    output logic [7:0]           rdata,
    output logic                 rvalid,
    // power hardware
    input  wire logic [7:0]      prot_live,
    input  wire logic [7:0]      prot_event,
    input  wire logic [7:0]      std_event,
    input  wire logic            queue_nonempty,
    input  wire logic            msg_avail,
    // outputs
    output logic                 mode_shutdown,
    output logic                 srq_n
);
    localparam int M_PROT = 0;
    localparam int M_STD  = 1;
    localparam int M_SRQ  = 2;

    logic [2:0][7:0] mask;
    logic [2:0]      mask_we;
    logic [7:0] prot_latched, next_prot_latched;
    logic [7:0] std_latched, next_std_latched;
    logic       request_service_bit, next_rqs;
    logic       std_sum;
    logic [7:0] stb_src;
    logic [7:0] next_rdata;
    logic       rd_prot, rd_std, rd_poll, clr;

    function automatic logic is_rd(input ssr_pkg::ssr_acc_t a,
                                   input logic [2:0] s);
        is_rd = a.rd && (a.sel == s);
    endfunction : is_rd

    function automatic logic is_wr(input ssr_pkg::ssr_acc_t a,
                                   input logic [2:0] s);
        is_wr = a.wr && (a.sel == s);
    endfunction : is_wr

    assign rd_prot = is_rd(acc, ssr_pkg::SEL_PROT_EVT);  // R18
    assign rd_std  = is_rd(acc, ssr_pkg::SEL_STD_EVT);
    assign rd_poll = is_rd(acc, ssr_pkg::SEL_POLL) && gpib_sel;  // R12
    assign clr     = cmd.clear_status;

    assign mask_we[M_PROT] = is_wr(acc, ssr_pkg::SEL_PROT_MASK);  // R06
    assign mask_we[M_STD]  = is_wr(acc, ssr_pkg::SEL_STD_MASK);
    assign mask_we[M_SRQ]  = is_wr(acc, ssr_pkg::SEL_SRQ_MASK);  // R13

    // masks survive clear-status; only reset puts them back
    ssr_mask_regs #(.N(3)) u_masks (
        .core_clk (core_clk),
        .rstn     (rstn),
        .we       (mask_we),
        .wdata    (acc.wdata),
        .clr_all  (1'b0),
        .mask     (mask)
    );

    // latched protection events
    always_comb begin
        next_prot_latched = prot_latched;
        if (rd_prot || clr || cmd.reset_cmd)  // R02 R03
            next_prot_latched = '0;
        // a new enabled event wins over the clearing read
        next_prot_latched = next_prot_latched |
            (prot_event & mask[M_PROT] & ssr_pkg::PROT_USED_MASK);  // R04 R05
    end

    // standard event latch
    always_comb begin
        next_std_latched = std_latched;
        if (rd_std || clr)  // R09
            next_std_latched = '0;
        next_std_latched = next_std_latched |
            (std_event & ssr_pkg::STD_USED_MASK);  // R10
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            prot_latched <= '0;
            std_latched  <= ssr_pkg::STD_RESET;
        end else begin
            prot_latched <= next_prot_latched;
            std_latched  <= next_std_latched;
        end
    end

    // summary follows the latch, so a read clears it with the latch
    assign std_sum = |(std_latched & mask[M_STD]);  // R11 R17

    always_comb begin
        stb_src = '0;
        stb_src[ssr_pkg::STB_PROT_BIT] = |prot_latched;
        stb_src[2] = queue_nonempty;
        stb_src[4] = msg_avail;
        stb_src[ssr_pkg::STB_STD_BIT] = std_sum;
    end

    // request-service: raised by any enabled status byte bit, cleared by poll
    always_comb begin
        next_rqs = request_service_bit;
        if (rd_poll || clr)  // R16 R12
            next_rqs = 1'b0;
        if (|(stb_src & mask[M_SRQ] & ssr_pkg::STB_SRC_MASK))  // R14 R08
            next_rqs = 1'b1;
    end

    // read data: poll returns the bit value before it clears
    always_comb begin
        next_rdata = '0;
        case (acc.sel)
            ssr_pkg::SEL_PROT_LIVE: next_rdata = prot_live &
                                        ssr_pkg::PROT_USED_MASK;  // R01
            ssr_pkg::SEL_PROT_EVT:  next_rdata = prot_latched;
            ssr_pkg::SEL_PROT_MASK: next_rdata = mask[M_PROT];
            ssr_pkg::SEL_STD_EVT:   next_rdata = std_latched;
            ssr_pkg::SEL_STD_MASK:  next_rdata = mask[M_STD];
            ssr_pkg::SEL_STB,
            ssr_pkg::SEL_POLL: begin
                next_rdata = stb_src;
                next_rdata[ssr_pkg::STB_RQS_BIT] = request_service_bit;
            end
            ssr_pkg::SEL_SRQ_MASK:  next_rdata = mask[M_SRQ];
            default:                next_rdata = '0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            request_service_bit    <= 1'b0;
            rdata  <= '0;
            rvalid <= 1'b0;
        end else begin
            request_service_bit    <= next_rqs;
            rvalid <= acc.rd;
            if (acc.rd)
                rdata <= next_rdata;
        end
    end

    // serial and network links have no request line
    assign srq_n = ~(request_service_bit && gpib_sel);  // R15

    // mode changes only shut down when their enable bit is set
    assign mode_shutdown = |(prot_event & mask[M_PROT] &
                             ssr_pkg::PROT_MODE_MASK);  // R07

    a_prot_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        (rd_prot && prot_event == 8'h00) |=> prot_latched == 8'h00)  // R02
        else $error("protection events not cleared by read");
    a_prot_cmd: assert property (@(posedge core_clk) disable iff (!rstn)
        (cmd.reset_cmd && prot_event == 8'h00) |=> prot_latched == 8'h00)  // R03
        else $error("protection events not cleared by command");
    a_prot_filter: assert property (@(posedge core_clk) disable iff (!rstn)
        (!rd_prot && !clr && !cmd.reset_cmd) |=>
        ((prot_latched & ~$past(prot_latched)) &
         ~$past(prot_event & mask[M_PROT])) == 8'h00)  // R04
        else $error("protection event set without enable");
    a_prot_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        (!rd_prot && !clr && !cmd.reset_cmd) |=>
        (($past(prot_latched) & ~prot_latched) == 8'h00))  // R04
        else $error("protection event dropped");
    a_prot_bit2: assert property (@(posedge core_clk) disable iff (!rstn)
        prot_latched[2] == 1'b0)  // R05
        else $error("unused protection bit set");
    a_std_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        ((rd_std || clr) && std_event == 8'h00) |=> std_latched == 8'h00)  // R09
        else $error("standard events not cleared");
    a_std_unused: assert property (@(posedge core_clk) disable iff (!rstn)
        (std_latched & 8'h42) == 8'h00)  // R10
        else $error("unused standard event bit set");
    a_std_sum: assert property (@(posedge core_clk) disable iff (!rstn)
        (acc.rd && acc.sel == ssr_pkg::SEL_STB) |=>
        rdata[5] == $past(|(std_latched & mask[M_STD])))  // R11
        else $error("standard summary wrong in status byte");
    sequence s_srq_enabled;
        (|(stb_src & mask[M_SRQ] & ssr_pkg::STB_SRC_MASK));
    endsequence
    a_rqs_set: assert property (@(posedge core_clk) disable iff (!rstn)
        s_srq_enabled |=> request_service_bit ##0 (srq_n == !gpib_sel))  // R14 R15
        else $error("request-service not raised");
    a_srq_gpib: assert property (@(posedge core_clk) disable iff (!rstn)
        !gpib_sel |-> srq_n)  // R15
        else $error("request line driven off GPIB");
    a_poll_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        (rd_poll && !$rose(request_service_bit) && !(|(stb_src & mask[M_SRQ]))) |=>
        !request_service_bit ##0 rdata[6] == $past(request_service_bit))  // R16
        else $error("poll did not return and clear request bit");
    a_live_read: assert property (@(posedge core_clk) disable iff (!rstn)
        (acc.rd && acc.sel == ssr_pkg::SEL_PROT_LIVE) |=>
        rvalid && rdata == ($past(prot_live) & 8'hfb))  // R01
        else $error("live state read wrong");
    a_mode_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        ((mask[M_PROT] & ssr_pkg::PROT_MODE_MASK) == 8'h00) |-> !mode_shutdown)  // R07
        else $error("shutdown from disabled mode bit");
    a_mask_write: assert property (@(posedge core_clk) disable iff (!rstn)
        is_wr(acc, ssr_pkg::SEL_SRQ_MASK) |=> mask[M_SRQ] == $past(acc.wdata))  // R13
        else $error("service mask not written");
endmodule : ssr_status
`default_nettype wire

// ---- verification/ssr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side: command interpreter issuing register strobes
module ssr_host (
    // clock
    input  wire logic             core_clk,
    // access side
    output var ssr_pkg::ssr_acc_t acc,
    output var ssr_pkg::ssr_cmd_t cmd,
    input  wire logic [7:0]       rdata,
    input  wire logic             rvalid
);
    initial begin
        acc = '0;
        cmd = '0;
    end

    // one-cycle strobe, answer taken one edge later
    task automatic rd(input logic [2:0] s, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        acc.sel = s;
        acc.rd  = 1'b1;
        @(posedge core_clk);
        #1;
        acc.rd = 1'b0;
        d = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask : rd

    task automatic wr(input logic [2:0] s, input logic [7:0] v);
        @(posedge core_clk);
        #1;
        acc.sel   = s;
        acc.wdata = v;
        acc.wr    = 1'b1;
        @(posedge core_clk);
        #1;
        acc.wr = 1'b0;
    endtask : wr

    // pulse clear-status (st=1) or the reset command (st=0)
    task automatic clear(input logic st);
        @(posedge core_clk);
        #1;
        cmd = st ? 2'b10 : 2'b01;
        @(posedge core_clk);
        #1;
        cmd = '0;
    endtask : clear
endmodule : ssr_host
`default_nettype wire

// ---- verification/ssr_status_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssr_status_bench;
    logic              core_clk;
    logic              rstn;
    logic              gpib_sel;
    logic              queue_nonempty;
    logic              msg_avail;
    logic [7:0]        prot_live;
    logic [7:0]        prot_event;
    logic [7:0]        std_event;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              mode_shutdown;
    logic              srq_n;
    ssr_pkg::ssr_acc_t acc;
    ssr_pkg::ssr_cmd_t cmd;
    int                mismatches;
    int                cmp_count;
    int                cycles;

    ssr_status ssr_status_inst (.core_clk(core_clk), .rstn(rstn), .acc(acc),
        .cmd(cmd), .gpib_sel(gpib_sel), .rdata(rdata), .rvalid(rvalid),
        .prot_live(prot_live), .prot_event(prot_event),
        .std_event(std_event), .queue_nonempty(queue_nonempty),
        .msg_avail(msg_avail), .mode_shutdown(mode_shutdown), .srq_n(srq_n));
    ssr_host ssr_host_inst (.core_clk(core_clk), .acc(acc), .cmd(cmd),
        .rdata(rdata), .rvalid(rvalid));

    always #2 core_clk = ~core_clk;

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // generous ceiling: the whole run needs under 150 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rdc(input logic [2:0] s, input logic [7:0] e, input string n);
        logic [7:0] d;
        ssr_host_inst.rd(s, d);
        chk(n, e, d);
    endtask : rdc

    task automatic ev(input logic [7:0] p, input logic [7:0] s);
        @(posedge core_clk);
        #1;
        prot_event = p;
        std_event  = s;
        @(posedge core_clk);
        #1;
        prot_event = 8'h00;
        std_event  = 8'h00;
    endtask : ev

    task automatic t_reset;
        rdc(ssr_pkg::SEL_PROT_MASK, 8'h00, "prot mask");
        rdc(ssr_pkg::SEL_STD_MASK, 8'h00, "std mask");
        rdc(ssr_pkg::SEL_SRQ_MASK, 8'h00, "srq mask");
        rdc(ssr_pkg::SEL_STD_EVT, 8'h80, "power on");
        rdc(ssr_pkg::SEL_STD_EVT, 8'h00, "std after read");
        chk("srq_n idle", 8'h01, {7'h00, srq_n});
    endtask : t_reset

    task automatic t_live;
        prot_live = 8'h5a;
        rdc(ssr_pkg::SEL_PROT_LIVE, 8'h5a, "live");
        prot_live = 8'ha5;
        // bit2 is unused and always reads zero
        rdc(ssr_pkg::SEL_PROT_LIVE, 8'ha1, "live moved");
        rdc(ssr_pkg::SEL_PROT_LIVE, 8'ha1, "live again");
    endtask : t_live

    task automatic t_prot;
        ev(8'hff, 8'h00);
        rdc(ssr_pkg::SEL_PROT_EVT, 8'h00, "masked event");
        ssr_host_inst.wr(ssr_pkg::SEL_PROT_MASK, 8'hff);
        rdc(ssr_pkg::SEL_PROT_MASK, 8'hff, "prot mask rw");
        ev(8'hff, 8'h00);
        rdc(ssr_pkg::SEL_PROT_EVT, 8'hfb, "all events");
        rdc(ssr_pkg::SEL_PROT_EVT, 8'h00, "read clears");
        ssr_host_inst.wr(ssr_pkg::SEL_PROT_MASK, 8'h18);
        ev(8'h18, 8'h00);
        repeat (5) @(posedge core_clk);
        rdc(ssr_pkg::SEL_PROT_EVT, 8'h18, "latched");
        ev(8'h18, 8'h00);
        ssr_host_inst.clear(1'b0);
        rdc(ssr_pkg::SEL_PROT_EVT, 8'h00, "reset cmd");
        ev(8'h08, 8'h00);
        ssr_host_inst.clear(1'b1);
        rdc(ssr_pkg::SEL_PROT_EVT, 8'h00, "clear status");
    endtask : t_prot

    task automatic t_mode;
        ssr_host_inst.wr(ssr_pkg::SEL_PROT_MASK, 8'h00);
        prot_event = 8'h43;
        repeat (2) @(posedge core_clk);
        chk("no shutdown", 8'h00, {7'h00, mode_shutdown});
        ssr_host_inst.wr(ssr_pkg::SEL_PROT_MASK, 8'h01);
        @(posedge core_clk);
        #1;
        chk("cv shutdown", 8'h01, {7'h00, mode_shutdown});
        prot_event = 8'h00;
        ssr_host_inst.wr(ssr_pkg::SEL_PROT_MASK, 8'h00);
        rdc(ssr_pkg::SEL_PROT_EVT, 8'h01, "cv latched");
    endtask : t_mode

    task automatic t_std;
        queue_nonempty = 1'b1;
        msg_avail      = 1'b1;
        ssr_host_inst.wr(ssr_pkg::SEL_STD_MASK, 8'h20);
        rdc(ssr_pkg::SEL_STD_MASK, 8'h20, "std mask rw");
        ev(8'h00, 8'h20);
        rdc(ssr_pkg::SEL_STB, 8'h34, "summary set");
        rdc(ssr_pkg::SEL_STD_EVT, 8'h20, "std latch");
        rdc(ssr_pkg::SEL_STB, 8'h14, "summary cleared");
        ev(8'h00, 8'h01);
        rdc(ssr_pkg::SEL_STB, 8'h14, "masked std");
        queue_nonempty = 1'b0;
        msg_avail      = 1'b0;
        ev(8'h00, 8'h20);
        ssr_host_inst.clear(1'b1);
        rdc(ssr_pkg::SEL_STD_EVT, 8'h00, "std cleared");
        rdc(ssr_pkg::SEL_STB, 8'h00, "stb cleared");
    endtask : t_std

    task automatic t_srq;
        gpib_sel = 1'b1;
        ssr_host_inst.wr(ssr_pkg::SEL_PROT_MASK, 8'h08);
        ssr_host_inst.wr(ssr_pkg::SEL_SRQ_MASK, 8'h02);
        rdc(ssr_pkg::SEL_SRQ_MASK, 8'h02, "srq mask rw");
        ev(8'h08, 8'h00);
        rdc(ssr_pkg::SEL_STB, 8'h42, "stb query");
        chk("srq_n gpib", 8'h00, {7'h00, srq_n});
        gpib_sel = 1'b0;
        @(posedge core_clk);
        #1;
        chk("srq_n serial", 8'h01, {7'h00, srq_n});
        // poll off gpib only reads, rqs must survive it
        rdc(ssr_pkg::SEL_POLL, 8'h42, "poll off gpib");
        gpib_sel = 1'b1;
        rdc(ssr_pkg::SEL_PROT_EVT, 8'h08, "source read");
        rdc(ssr_pkg::SEL_POLL, 8'h40, "poll rqs");
        rdc(ssr_pkg::SEL_POLL, 8'h00, "poll cleared");
        chk("srq_n released", 8'h01, {7'h00, srq_n});
    endtask : t_srq

    initial begin
        core_clk       = 1'b0;
        rstn           = 1'b0;
        gpib_sel       = 1'b0;
        queue_nonempty = 1'b0;
        msg_avail      = 1'b0;
        prot_live      = 8'h00;
        prot_event     = 8'h00;
        std_event      = 8'h00;
        repeat (16) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_live();
        t_prot();
        t_mode();
        t_std();
        t_srq();
        conclude();
    end
endmodule : ssr_status_bench
`default_nettype wire
